// *** rtl/ihs_pkg.sv ***
package ihs_pkg;
	// ----------------------------------------
	// Sequencer states
	// ----------------------------------------
	typedef enum logic [3:0] {
		ST_IDLE   = 4'h0,
		ST_START  = 4'h1,
		ST_RSTART = 4'h2,
		ST_TX     = 4'h3,
		ST_RX     = 4'h4,
		ST_ACK    = 4'h5,
		ST_STOP   = 4'h6
	} ihs_state_t;

	// ----------------------------------------
	// Counts, phase codes and reset values
	// ----------------------------------------
	localparam logic [3:0] BITS_PER_BYTE   = 4'h8;
	localparam logic [3:0] BITS_WITH_ACK   = 4'h9;
	localparam logic [7:0] BUF_RESET       = 8'h00;
	localparam logic [1:0] PHASE_LOW       = 2'h0;
	localparam logic [1:0] PHASE_HIGH      = 2'h1;
	localparam logic [1:0] PHASE_END       = 2'h2;
	localparam logic [1:0] PHASE_TAIL      = 2'h3;
	localparam logic [7:0] BAUD_RELOAD_RST = 8'h04;
endpackage : ihs_pkg

// *** rtl/ihs_link_if.sv ***
`timescale 1ns/1ps
// ----------------------------------------
// Pin levels crossing into the system domain
// ----------------------------------------
interface ihs_link_if;
	logic sda_level;
	logic scl_level;
	modport src (output sda_level, output scl_level);
	modport dst (input sda_level, input scl_level);
endinterface : ihs_link_if

// *** rtl/ihs_pin_sync.sv ***
`timescale 1ns/1ps
// ----------------------------------------
// Two-flop synchroniser of SDA and SCL
// ----------------------------------------
module ihs_pin_sync (
	input  wire logic      i_sys_clk,
	input  wire logic      i_rstn,
	input  wire logic      i_sda,
	input  wire logic      i_scl,
	ihs_link_if.src        link
);
	typedef struct packed {
		logic [1:0] sda;
		logic [1:0] scl;
	} ihs_sync_t;

	ihs_sync_t st_q;
	ihs_sync_t st_d;

	always_comb begin
		st_d     = st_q;
		st_d.sda = {st_q.sda[0], i_sda};
		st_d.scl = {st_q.scl[0], i_scl};
	end

	always_ff @(posedge i_sys_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			st_q <= '1;
		end else begin
			st_q <= st_d;
		end
	end

	assign link.sda_level = st_q.sda[1];
	assign link.scl_level = st_q.scl[1];
endmodule : ihs_pin_sync

// *** rtl/ihs_host_seq.sv ***
`timescale 1ns/1ps
// Behaviour
// - Buffer write while shifting out sets write collision; buffer unchanged.
// - Ack status cleared on client ack low, set on high.
// - Buffer write when idle shifts eight bits MSB first, ninth samples ack.
// - Interrupt flag set after ninth clock of each transmitted byte.
// - Completed start sets interrupt flag; software clears before address.
// - Receive request accepted only when idle, ignored otherwise.
// - In reception each baud rollover toggles SCL; SDA shifted in.
// - After eighth fall: return to idle, load buffer, set full and interrupt, hold SCL.
// - Full flag set on receive load, cleared when software reads buffer.
// - Overflow set when byte completes while full still set.
// - Buffer write during reception sets write collision, discarded.
// - Ack sequence: SCL low, drive ack value, release, high period, low, idle.
// - Buffer write during ack sequence sets write collision, discarded.
// - Stop: SDA low, count, release SCL, release SDA one period later.
// - SDA rising with SCL high sets stop seen; two periods after SDA release interrupt.
// - Buffer write during stop sets write collision, discarded.
// - Reset returns to idle, releases both lines and aborts any transfer.
// - Start and stop seen cleared by reset or disable.
// - Bus stop detected after start seen, outside own stop state, raises interrupt flag.
// - Driven SDA compared with sampled SDA; mismatch sets bus collision.
// - Each baud period reloads from reload value; held while released SCL still low.
// - On collision halt, clear full, release lines, accept new write.
module ihs_host_seq #(
	parameter int BAUD_W = 8
) (
	input  wire logic              i_sys_clk,
	input  wire logic              i_rstn,
	input  wire logic              i_clk_en,
	input  wire logic              i_port_enable,
	input  wire logic [BAUD_W-1:0] i_baud_reload_value,
	input  wire logic              i_buf_wr,
	input  wire logic [7:0]        i_buf_wdata,
	input  wire logic              i_buf_rd,
	input  wire logic              i_start_request_bit,
	input  wire logic              i_repeated_start_request_bit,
	input  wire logic              i_receive_request_bit,
	input  wire logic              i_ack_sequence_request_bit,
	input  wire logic              i_stop_request_bit,
	input  wire logic              i_ack_value_bit,
	input  wire logic              i_clr_write_collision,
	input  wire logic              i_clr_overflow,
	input  wire logic              i_clr_interrupt,
	input  wire logic              i_clr_bus_collision,
	input  wire logic              i_sda,
	input  wire logic              i_scl,
	output logic                   o_sda_o,
	output logic                   o_sda_oe,
	output logic                   o_scl_o,
	output logic                   o_scl_oe,
	output logic [7:0]             o_transfer_buffer,
	output logic                   o_busy,
	output logic                   o_write_collision_flag,
	output logic                   o_ack_status_bit,
	output logic                   o_buffer_full_flag,
	output logic                   o_receive_overflow_flag,
	output logic                   o_port_interrupt_flag,
	output logic                   o_bus_collision_flag,
	output logic                   o_start_seen,
	output logic                   o_stop_seen
);
	initial begin
		if (BAUD_W < 2 || BAUD_W > 16) begin
			$error("BAUD_W out of range");
		end
	end

	// ----------------------------------------
	// Synchronised pins
	// ----------------------------------------
	ihs_link_if link ();

	ihs_pin_sync u_sync (
		.i_sys_clk (i_sys_clk),
		.i_rstn    (i_rstn),
		.i_sda     (i_sda),
		.i_scl     (i_scl),
		.link      (link)
	);

	// ----------------------------------------
	// State
	// ----------------------------------------
	typedef struct packed {
		ihs_pkg::ihs_state_t st;
		logic                busy;
		logic [BAUD_W-1:0]   brg;
		logic [3:0]          bitn;
		logic [1:0]          ph;
		logic [7:0]          shreg;
		logic [7:0]          tbuf;
		logic                sda_low;
		logic                scl_low;
		logic                write_collision_flag;
		logic                ack_status_bit;
		logic                bf;
		logic                ov;
		logic                irq;
		logic                bcol;
		logic                s_seen;
		logic                p_seen;
		logic                sda_prev;
		logic                scl_prev;
	} ihs_core_t;

	ihs_core_t cq;
	ihs_core_t cd;

	logic sda_in;
	logic scl_in;
	assign sda_in = link.sda_level;
	assign scl_in = link.scl_level;

	function automatic logic [BAUD_W-1:0] reload(input logic [BAUD_W-1:0] v);
		reload = v;
	endfunction : reload

	logic tick;
	logic run_ok;
	logic bcol_keep;

	always_comb begin
		cd       = cq;
		tick     = 1'b0;
		// Hold count while released SCL still low
		run_ok   = !(!cq.scl_low && !scl_in);
		cd.sda_prev = sda_in;
		cd.scl_prev = scl_in;
		if (cq.st != ihs_pkg::ST_IDLE && run_ok) begin
			if (cq.brg == '0) begin
				tick   = 1'b1;
				cd.brg = reload(i_baud_reload_value);
			end else begin
				cd.brg = cq.brg - 1'b1;
			end
		end
		if (i_clr_interrupt) cd.irq = 1'b0;
		// Bus start and stop monitor
		if (cq.scl_prev && scl_in && cq.sda_prev && !sda_in) begin
			cd.s_seen = 1'b1;
			cd.p_seen = 1'b0;
		end
		if (cq.scl_prev && scl_in && !cq.sda_prev && sda_in) begin
			cd.p_seen = 1'b1;
			cd.s_seen = 1'b0;
			if (cq.s_seen && cq.st != ihs_pkg::ST_STOP) begin
				cd.irq = 1'b1;
			end
		end
		// Software clears, set wins below
		if (i_clr_write_collision) cd.write_collision_flag = 1'b0;
		if (i_clr_overflow)        cd.ov   = 1'b0;
		if (i_clr_bus_collision)   cd.bcol = 1'b0;
		if (i_buf_rd && cq.st != ihs_pkg::ST_TX) begin
			cd.bf = 1'b0;
		end
		if (i_buf_wr && cq.st != ihs_pkg::ST_IDLE) begin
			cd.write_collision_flag = 1'b1;
		end
		// Only a collision of this cycle aborts
		bcol_keep = cd.bcol;
		cd.bcol   = 1'b0;
		unique case (cq.st)
			ihs_pkg::ST_IDLE: begin
				cd.ph  = ihs_pkg::PHASE_LOW;
				cd.brg = reload(i_baud_reload_value);
				if (i_buf_wr) begin
					cd.tbuf  = i_buf_wdata;
					cd.shreg = i_buf_wdata;
					cd.bf    = 1'b1;
					cd.bitn  = '0;
					cd.scl_low = 1'b1;
					cd.st    = ihs_pkg::ST_TX;
				end else if (i_start_request_bit) begin
					if (!sda_in || !scl_in) begin
						cd.bcol = 1'b1;
					end else begin
						cd.st = ihs_pkg::ST_START;
					end
				end else if (i_repeated_start_request_bit) begin
					cd.scl_low = 1'b1;
					cd.sda_low = 1'b0;
					cd.st      = ihs_pkg::ST_RSTART;
				end else if (i_receive_request_bit) begin
					cd.scl_low = 1'b1;
					cd.sda_low = 1'b0;
					cd.bitn    = '0;
					cd.st      = ihs_pkg::ST_RX;
				end else if (i_ack_sequence_request_bit) begin
					cd.scl_low = 1'b1;
					cd.sda_low = !i_ack_value_bit;
					cd.st      = ihs_pkg::ST_ACK;
				end else if (i_stop_request_bit) begin
					cd.sda_low = 1'b1;
					cd.st      = ihs_pkg::ST_STOP;
				end
			end
			ihs_pkg::ST_START: begin
				if (!scl_in && !cq.sda_low) begin
					cd.bcol = 1'b1;
				end else if (tick) begin
					if (!cq.sda_low) begin
						cd.sda_low = 1'b1;
					end else begin
						cd.scl_low = 1'b1;
						cd.irq     = 1'b1;
						cd.st      = ihs_pkg::ST_IDLE;
					end
				end
			end
			ihs_pkg::ST_RSTART: begin
				if (tick) begin
					unique case (cq.ph)
						ihs_pkg::PHASE_LOW: begin
							cd.scl_low = 1'b0;
							cd.ph      = ihs_pkg::PHASE_HIGH;
						end
						ihs_pkg::PHASE_HIGH: begin
							if (!sda_in) begin
								cd.bcol = 1'b1;
							end
							cd.sda_low = 1'b1;
							cd.ph      = ihs_pkg::PHASE_END;
						end
						default: begin
							cd.scl_low = 1'b1;
							cd.irq     = 1'b1;
							cd.st      = ihs_pkg::ST_IDLE;
						end
					endcase
				end
			end
			ihs_pkg::ST_TX: begin
				if (tick) begin
					if (cq.scl_low) begin
						cd.scl_low = 1'b0;
						cd.sda_low = (cq.bitn < ihs_pkg::BITS_PER_BYTE) ? !cq.shreg[7] : 1'b0;
					end else begin
						cd.scl_low = 1'b1;
						if (cq.bitn < ihs_pkg::BITS_PER_BYTE) begin
							if (!cq.sda_low && !sda_in) begin
								cd.bcol = 1'b1;
							end
							cd.shreg = {cq.shreg[6:0], 1'b0};
						end else begin
							cd.ack_status_bit = sda_in;
							cd.irq     = 1'b1;
							cd.st      = ihs_pkg::ST_IDLE;
						end
						if (cq.bitn == ihs_pkg::BITS_PER_BYTE - 4'h1) begin
							cd.bf = 1'b0;
						end
						cd.bitn = cq.bitn + 4'h1;
					end
				end
			end
			ihs_pkg::ST_RX: begin
				if (tick) begin
					cd.scl_low = !cq.scl_low;
					if (cq.scl_low) begin
						cd.shreg = {cq.shreg[6:0], sda_in};
					end else begin
						cd.bitn = cq.bitn + 4'h1;
						if (cq.bitn == ihs_pkg::BITS_PER_BYTE - 4'h1) begin
							if (cq.bf) begin
								cd.ov = 1'b1;
							end
							cd.tbuf = cq.shreg;
							cd.bf   = 1'b1;
							cd.irq  = 1'b1;
							cd.st   = ihs_pkg::ST_IDLE;
						end
					end
				end
			end
			ihs_pkg::ST_ACK: begin
				if (tick) begin
					if (cq.scl_low) begin
						cd.scl_low = 1'b0;
					end else begin
						if (!cq.sda_low && !sda_in) begin
							cd.bcol = 1'b1;
						end
						cd.scl_low = 1'b1;
						cd.irq     = 1'b1;
						cd.st      = ihs_pkg::ST_IDLE;
					end
				end
			end
			ihs_pkg::ST_STOP: begin
				if (tick) begin
					unique case (cq.ph)
						ihs_pkg::PHASE_LOW: begin
							cd.scl_low = 1'b0;
							cd.ph      = ihs_pkg::PHASE_HIGH;
						end
						ihs_pkg::PHASE_HIGH: begin
							cd.sda_low = 1'b0;
							cd.ph      = ihs_pkg::PHASE_END;
						end
						ihs_pkg::PHASE_END: begin
							if (!sda_in) begin
								cd.bcol = 1'b1;
							end
							cd.ph = ihs_pkg::PHASE_TAIL;
						end
						default: begin
							cd.irq = 1'b1;
							cd.st  = ihs_pkg::ST_IDLE;
						end
					endcase
				end
			end
			default: begin
				cd.st = ihs_pkg::ST_IDLE;
			end
		endcase
		// Collision abort
		if (cd.bcol) begin
			cd.st      = ihs_pkg::ST_IDLE;
			cd.bf      = 1'b0;
			cd.sda_low = 1'b0;
			cd.scl_low = 1'b0;
		end
		cd.bcol = cd.bcol | bcol_keep;
		// Disabled port
		if (!i_port_enable) begin
			cd.st      = ihs_pkg::ST_IDLE;
			cd.sda_low = 1'b0;
			cd.scl_low = 1'b0;
			cd.s_seen  = 1'b0;
			cd.p_seen  = 1'b0;
		end
		cd.busy = (cd.st != ihs_pkg::ST_IDLE);
	end

	always_ff @(posedge i_sys_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			cq          <= '0;
			cq.st       <= ihs_pkg::ST_IDLE;
			cq.tbuf     <= ihs_pkg::BUF_RESET;
			cq.sda_prev <= 1'b1;
			cq.scl_prev <= 1'b1;
		end else if (i_clk_en) begin
			cq <= cd;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign o_sda_o                 = 1'b0;
	assign o_sda_oe                = cq.sda_low;
	assign o_scl_o                 = 1'b0;
	assign o_scl_oe                = cq.scl_low;
	assign o_transfer_buffer       = cq.tbuf;
	assign o_busy                  = cq.busy;
	assign o_write_collision_flag  = cq.write_collision_flag;
	assign o_ack_status_bit        = cq.ack_status_bit;
	assign o_buffer_full_flag      = cq.bf;
	assign o_receive_overflow_flag = cq.ov;
	assign o_port_interrupt_flag   = cq.irq;
	assign o_bus_collision_flag    = cq.bcol;
	assign o_start_seen            = cq.s_seen;
	assign o_stop_seen             = cq.p_seen;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	a_write_collision_flag_sets: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
		i_clk_en && i_buf_wr && o_busy |=> o_write_collision_flag)
		else $error("write collision not set");
	a_buf_kept: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
		i_clk_en && i_buf_wr && o_busy && cq.st == ihs_pkg::ST_STOP |=> $stable(o_transfer_buffer))
		else $error("buffer changed in stop");
	a_write_collision_flag_sticky: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
		o_write_collision_flag && !i_clr_write_collision |=> o_write_collision_flag)
		else $error("write collision dropped");
	a_tx_start: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
		i_clk_en && i_port_enable && !o_busy && i_buf_wr |=> cq.st == ihs_pkg::ST_TX && o_buffer_full_flag)
		else $error("transmit did not start");
	sequence s_rx_done;
		cq.st == ihs_pkg::ST_RX && i_port_enable ##1 cq.st == ihs_pkg::ST_IDLE;
	endsequence
	a_rx_load: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
		s_rx_done |-> o_port_interrupt_flag && o_buffer_full_flag)
		else $error("receive end flags missing");
	a_rx_ignore: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
		i_clk_en && o_busy && cq.st != ihs_pkg::ST_RX |=> cq.st != ihs_pkg::ST_RX)
		else $error("receive accepted while busy");
	a_disable_clr: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
		i_clk_en && !i_port_enable |=> !o_start_seen && !o_stop_seen && !o_busy)
		else $error("disable did not clear");
	a_open_drain: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
		!o_sda_o && !o_scl_o)
		else $error("line driven high");
endmodule : ihs_host_seq

// *** tb/ihs_client_model.sv ***
`timescale 1ns/1ps
// ----------------------------------------
// Behavioural bus client
// ----------------------------------------
module ihs_client_model #(
	parameter logic [6:0] ADDR = 7'h2a
) (
	input  wire logic       i_lk_clk,
	input  wire logic       i_sda,
	input  wire logic       i_scl,
	input  wire logic [7:0] i_tx_byte,
	input  wire logic       i_collide,
	output logic            o_sda_pull,
	output logic [7:0]      o_rx_byte
);
	logic       sda_q   = 1'b1;
	logic       scl_q   = 1'b1;
	logic       pull_q  = 1'b0;
	logic       first_q = 1'b1;
	logic       sel_q   = 1'b0;
	logic       rd_q    = 1'b0;
	logic [3:0] cnt_q   = 4'h0;
	logic [7:0] sh_q    = 8'h00;

	assign o_sda_pull = pull_q | i_collide;

	always @(posedge i_lk_clk) begin
		sda_q <= i_sda;
		scl_q <= i_scl;
		if (scl_q && i_scl && (sda_q != i_sda)) begin
			cnt_q   <= 4'h0;
			first_q <= 1'b1;
			pull_q  <= 1'b0;
		end else if (!scl_q && i_scl) begin
			cnt_q <= cnt_q + 4'h1;
			sh_q  <= {sh_q[6:0], i_sda};
		end else if (scl_q && !i_scl) begin
			if (cnt_q == 4'h8) begin
				o_rx_byte <= sh_q;
				if (first_q) begin
					sel_q  <= (sh_q[7:1] == ADDR);
					rd_q   <= sh_q[0];
					pull_q <= (sh_q[7:1] == ADDR);
				end else begin
					pull_q <= sel_q && !rd_q;
				end
			end else if (cnt_q == 4'h9) begin
				first_q <= 1'b0;
				cnt_q   <= 4'h0;
				pull_q  <= sel_q && rd_q && !i_tx_byte[7];
			end else if (cnt_q != 4'h0 && sel_q && rd_q && !first_q) begin
				pull_q <= !i_tx_byte[4'h7 - cnt_q];
			end
		end
	end
endmodule : ihs_client_model

// *** tb/i2c_host_transfer_sequencer_tb.sv ***
`timescale 1ns/1ps
module i2c_host_transfer_sequencer_tb;
	localparam logic [10:0] P_ST = 11'h001, P_RX = 11'h002, P_AK = 11'h004, P_SP = 11'h008, P_WR = 11'h010;
	localparam logic [10:0] P_RD = 11'h020, P_CW = 11'h040, P_CI = 11'h080, P_CO = 11'h100, P_CB = 11'h200;
	localparam logic [10:0] P_RS = 11'h400;
	logic        clk, lk_clk, rstn, en, ce, ackv, collide, sda, scl, c_pull;
	logic        sda_o, sda_oe, scl_o, scl_oe, busy, write_collision_flag, ackst, bf, ovf, irq, bcl, st_seen, sp_seen;
	logic [10:0] rq;
	logic [7:0]  wdata, tbuf, c_rx;
	int          n_mismatch, num_checks;
	int          cyc = 0;

	// ----------------------------------------
	// Clocks, wires and instances
	// ----------------------------------------
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	initial begin
		lk_clk = 1'b0;
		#3.1;
		forever #7.5 lk_clk = ~lk_clk;
	end
	assign sda = !(sda_oe || c_pull);
	assign scl = !scl_oe;

	ihs_host_seq i_ihs_host_seq (
		.i_sys_clk(clk), .i_rstn(rstn), .i_clk_en(ce), .i_port_enable(en), .i_baud_reload_value(8'h0f),
		.i_buf_wr(rq[4]), .i_buf_wdata(wdata), .i_buf_rd(rq[5]), .i_start_request_bit(rq[0]),
		.i_repeated_start_request_bit(rq[10]), .i_receive_request_bit(rq[1]), .i_ack_sequence_request_bit(rq[2]),
		.i_stop_request_bit(rq[3]), .i_ack_value_bit(ackv), .i_clr_write_collision(rq[6]),
		.i_clr_overflow(rq[8]), .i_clr_interrupt(rq[7]), .i_clr_bus_collision(rq[9]), .i_sda(sda), .i_scl(scl),
		.o_sda_o(sda_o), .o_sda_oe(sda_oe), .o_scl_o(scl_o), .o_scl_oe(scl_oe), .o_transfer_buffer(tbuf),
		.o_busy(busy), .o_write_collision_flag(write_collision_flag), .o_ack_status_bit(ackst), .o_buffer_full_flag(bf),
		.o_receive_overflow_flag(ovf), .o_port_interrupt_flag(irq), .o_bus_collision_flag(bcl),
		.o_start_seen(st_seen), .o_stop_seen(sp_seen)
	);
	ihs_client_model i_ihs_client_model (
		.i_lk_clk(lk_clk), .i_sda(sda), .i_scl(scl), .i_tx_byte(8'ha5), .i_collide(collide),
		.o_sda_pull(c_pull), .o_rx_byte(c_rx)
	);

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	task automatic test_done;
		$display("checks=%0d mismatches=%0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : test_done

	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			n_mismatch++;
			test_done();
		end
	end

	task automatic chk1(input logic got, input logic exp);
		num_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("Error t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk1

	task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("Error t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk8

	task automatic pulse(input logic [10:0] m);
		@(posedge clk);
		rq <= m;
		@(posedge clk);
		rq <= 11'h000;
	endtask : pulse

	task automatic wait_for(input int s);
		int n;
		n = 0;
		do begin
			@(negedge clk);
			n++;
		end while (n < 4000 && !(s == 0 ? irq === 1'b1 : s == 1 ? busy === 1'b0 : bcl === 1'b1));
		if (n >= 4000) begin
			n_mismatch++;
			test_done();
		end
	endtask : wait_for

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_start;
		pulse(P_ST);
		wait_for(0);
		chk1(st_seen, 1'b1);
		pulse(P_CI);
	endtask : t_start

	task automatic t_tx(input logic [7:0] d, input logic a);
		wdata <= d;
		pulse(P_WR);
		wdata <= ~d;
		pulse(P_WR | P_RX);
		@(negedge clk);
		chk1(write_collision_flag, 1'b1);
		chk8(tbuf, d);
		wait_for(0);
		chk1(ackst, a);
		chk8(c_rx, d);
		chk1(busy, 1'b0);
		pulse(P_CI | P_CW);
	endtask : t_tx

	task automatic t_rx(input logic ov);
		pulse(P_RX);
		wdata <= 8'h11;
		pulse(P_WR);
		@(negedge clk);
		chk1(write_collision_flag, 1'b1);
		wait_for(0);
		chk8(tbuf, 8'ha5);
		chk1(bf, 1'b1);
		chk1(ovf, ov);
		chk1(scl_oe, 1'b1);
		pulse(P_CI | P_CW);
	endtask : t_rx

	task automatic t_ack(input logic v);
		ackv <= v;
		pulse(P_AK);
		wdata <= 8'h22;
		pulse(P_WR);
		repeat (3) @(negedge clk);
		chk1(sda_oe, !v);
		chk1(scl_oe, 1'b1);
		@(posedge clk);
		ce <= 1'b0;
		repeat (40) @(negedge clk);
		chk1(busy, 1'b1);
		chk1(scl_oe, 1'b1);
		@(posedge clk);
		ce <= 1'b1;
		wait_for(1);
		chk1(write_collision_flag, 1'b1);
		chk8(tbuf, 8'ha5);
		chk1(scl_oe, 1'b1);
		pulse(P_CI | P_CW);
	endtask : t_ack

	task automatic t_stop;
		pulse(P_SP);
		wdata <= 8'h33;
		pulse(P_WR);
		@(negedge clk);
		chk1(write_collision_flag, 1'b1);
		chk1(sda_oe, 1'b1);
		wait_for(0);
		chk1(sp_seen, 1'b1);
		chk1(sda_oe | scl_oe, 1'b0);
		pulse(P_CI | P_CW);
	endtask : t_stop

	task automatic t_rs;
		pulse(P_RS);
		wait_for(0);
		chk1(bcl, 1'b0);
		chk1(busy, 1'b0);
		chk1(sda_oe & scl_oe, 1'b1);
		chk1(sp_seen, 1'b0);
		pulse(P_CI);
	endtask : t_rs

	task automatic t_coll;
		t_start();
		collide <= 1'b1;
		wdata <= 8'hff;
		pulse(P_WR);
		wait_for(2);
		chk1(bcl, 1'b1);
		chk1(busy, 1'b0);
		chk1(bf, 1'b0);
		chk1(sda_oe | scl_oe, 1'b0);
		chk1(irq, 1'b0);
		@(posedge clk);
		collide <= 1'b0;
		repeat (6) @(negedge clk);
		chk1(sp_seen, 1'b1);
		chk1(irq, 1'b1);
		pulse(P_CB | P_CI | P_CW);
		wdata <= 8'h54;
		pulse(P_WR);
		@(negedge clk);
		chk1(write_collision_flag, 1'b0);
		chk8(tbuf, 8'h54);
		wait_for(0);
		pulse(P_CI);
	endtask : t_coll

	task automatic t_dis;
		@(posedge clk);
		en <= 1'b0;
		repeat (2) @(negedge clk);
		chk1(st_seen, 1'b0);
		chk1(sp_seen, 1'b0);
		chk1(sda_oe | scl_oe, 1'b0);
		@(posedge clk);
		en <= 1'b1;
	endtask : t_dis

	task automatic t_rst;
		t_start();
		wdata <= 8'h54;
		pulse(P_WR);
		repeat (20) @(posedge clk);
		rstn <= 1'b0;
		@(negedge clk);
		chk1(busy, 1'b0);
		chk1(sda_oe | scl_oe, 1'b0);
		chk1(st_seen, 1'b0);
		@(posedge clk);
		rstn <= 1'b1;
	endtask : t_rst

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		rstn = 1'b0;
		en = 1'b1;
		ackv = 1'b0;
		collide = 1'b0;
		rq = 11'h000;
		ce = 1'b1;
		wdata = 8'h00;
		n_mismatch = 0;
		num_checks = 0;
		repeat (6) @(posedge clk);
		rstn <= 1'b1;
		repeat (4) @(negedge clk);
		chk1(sda_o, 1'b0);
		chk1(scl_o, 1'b0);
		t_start();
		t_tx(8'h20, 1'b1);
		t_stop();
		t_start();
		t_tx(8'h54, 1'b0);
		t_tx(8'h3c, 1'b0);
		t_rs();
		t_tx(8'h20, 1'b1);
		t_stop();
		t_start();
		t_tx(8'h55, 1'b0);
		t_rx(1'b0);
		t_ack(1'b0);
		t_rx(1'b1);
		pulse(P_RD | P_CO);
		@(negedge clk);
		chk1(bf, 1'b0);
		t_ack(1'b1);
		t_stop();
		t_coll();
		t_stop();
		t_dis();
		t_rst();
		test_done();
	end
endmodule : i2c_host_transfer_sequencer_tb
